// [include/vrms_power_defines.svh]
// constants for the voltage rms offset and active power datapath
`ifndef VRMS_POWER_DEFINES_SVH
`define VRMS_POWER_DEFINES_SVH

// ****************************************************************
// widths
// ****************************************************************
`define NUM_PHASES        3
`define SAMPLE_W          24
`define SQ_W              48
`define REG_W             32
`define REG_ADDR_W        8
`define PHASE_IDX_W       2

// ****************************************************************
// timing
// ****************************************************************
`define CORE_CLK_HZ       25000000
`define RMS_UPDATE_HZ     8000
`define RMS_UPDATE_CYCLES (`CORE_CLK_HZ / `RMS_UPDATE_HZ)
`define TICK_CNT_W        12
`define SQRT_STEPS        24
`define SQRT_CNT_W        5

// ****************************************************************
// arithmetic
// ****************************************************************
`define VRMS_OFS_SHIFT    7
`define FULL_SCALE_POWER_CONSTANT 33516139
`define POWER_SCALE_SHIFT 23
`define SQRT_ONE_INIT     48'h400000000000
`define RMS_SAT_MAX       24'h7fffff
`define POWER_SAT_MAX     48'sh0000007fffff
`define POWER_SAT_MIN     48'shffffff800000
`define DEF_RMS_SHIFT     8
`define DEF_LPF_SHIFT     8
`define MAX_SHIFT         40
`define OFS_EXT_W         4

// ****************************************************************
// register map: group in addr[7:2], phase in addr[1:0]
// ****************************************************************
`define GRP_VRMS_OFS      6'h00
`define GRP_VRMS          6'h01
`define GRP_WATT          6'h02
`define GRP_FWATT         6'h03
`define VRMS_OFS_RESET    24'h000000
`define OFS_PAD_MSB       4'h0
`define RESULT_PAD        8'h00

`endif

// [include/vrms_power_pkg.sv]
// types shared by the rms and active power datapath
`include "vrms_power_defines.svh"
package vrms_power_pkg;
  typedef logic signed [`SAMPLE_W-1:0]   sample_t;
  typedef sample_t [`NUM_PHASES-1:0]     phase_sample_t;
  typedef logic [`SQ_W-1:0]              sq_t;
  typedef logic [`REG_W-1:0]             reg_word_t;
  typedef logic [`REG_ADDR_W-1:0]        reg_addr_t;
  typedef logic [`PHASE_IDX_W-1:0]       phase_idx_t;
  typedef enum logic [1:0] {
    RMS_IDLE,
    RMS_LOAD,
    RMS_ITER,
    RMS_STORE
  } rms_state_t;
endpackage

// [include/power_path_if.sv]
// carrier between the top and one power low-pass filter
`timescale 1ns/1ps
interface power_path_if;
  import vrms_power_pkg::*;
  logic    sample_valid;
  sample_t v_sample;
  sample_t i_sample;
  sample_t power_out;
  logic    power_valid;
  modport src  (output sample_valid, output v_sample, output i_sample,
                input power_out, input power_valid);
  modport filt (input sample_valid, input v_sample, input i_sample,
                output power_out, output power_valid);
endinterface

// [rtl/power_lowpass_filter.sv]
// multiplier and first-order low-pass filter for one phase power
`timescale 1ns/1ps
`include "vrms_power_defines.svh"
module power_lowpass_filter #(
  parameter int unsigned LPF_SHIFT = `DEF_LPF_SHIFT
) (
  input wire logic       core_clk, // device clock
  input wire logic       nrst,     // async reset, active low
  power_path_if.filt     pp        // samples in, power out
);
  import vrms_power_pkg::*;

  if (LPF_SHIFT < 1 || LPF_SHIFT > `MAX_SHIFT) begin : g_chk
    $error("power_lowpass_filter: LPF_SHIFT out of range");
  end

  // ****************************************************************
  // product and filter
  // ****************************************************************
  logic signed [`SQ_W-1:0] v_ext;
  logic signed [`SQ_W-1:0] i_ext;
  logic signed [`SQ_W-1:0] prod;
  logic signed [`SQ_W:0]   diff;
  logic signed [`SQ_W:0]   step;
  logic signed [`SQ_W:0]   acc_sum;
  logic signed [`SQ_W-1:0] acc_r;
  logic signed [`SQ_W-1:0] acc_nxt;
  logic signed [`SQ_W-1:0] scaled;
  logic signed [`SAMPLE_W-1:0] sat_out;
  logic                    upd_r;

  assign v_ext   = {{(`SQ_W-`SAMPLE_W){pp.v_sample[`SAMPLE_W-1]}}, pp.v_sample};
  assign i_ext   = {{(`SQ_W-`SAMPLE_W){pp.i_sample[`SAMPLE_W-1]}}, pp.i_sample};
  assign prod    = v_ext * i_ext;
  assign diff    = {prod[`SQ_W-1], prod} - {acc_r[`SQ_W-1], acc_r};
  assign step    = diff >>> LPF_SHIFT;
  assign acc_sum = {acc_r[`SQ_W-1], acc_r} + step;
  assign acc_nxt = acc_sum[`SQ_W-1:0];
  // full-scale dc >> 23 lands on the constant over sixteen
  assign scaled  = acc_r >>> `POWER_SCALE_SHIFT;
  assign sat_out = (scaled > `POWER_SAT_MAX) ? sample_t'(`POWER_SAT_MAX) :
                   (scaled < `POWER_SAT_MIN) ? sample_t'(`POWER_SAT_MIN) :
                   scaled[`SAMPLE_W-1:0];

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      acc_r <= '0;
      upd_r <= 1'b0;
    end else begin
      upd_r <= pp.sample_valid;
      if (pp.sample_valid) begin
        acc_r <= acc_nxt;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      pp.power_out   <= '0;
      pp.power_valid <= 1'b0;
    end else begin
      pp.power_valid <= upd_r;
      if (upd_r) begin
        pp.power_out <= sat_out;
      end
    end
  end
endmodule

// [rtl/vrms_offset_and_active_power.sv]
// per-phase voltage rms with offset correction and active power
`timescale 1ns/1ps
`include "vrms_power_defines.svh"
module vrms_offset_and_active_power #(
  parameter int unsigned RMS_SHIFT       = `DEF_RMS_SHIFT,
  parameter int unsigned LPF_SHIFT       = `DEF_LPF_SHIFT,
  parameter int unsigned UPDATE_CYCLES   = `RMS_UPDATE_CYCLES,
  parameter bit          HAS_FUNDAMENTAL = 1'b1
) (
  input  wire logic                          core_clk,      // device clock, 25 MHz
  input  wire logic                          nrst,          // async reset, active low
  input  wire logic                          sample_valid,  // one-cycle sample strobe
  input  wire vrms_power_pkg::phase_sample_t v_sample,      // voltage samples
  input  wire vrms_power_pkg::phase_sample_t i_sample,      // current samples
  input  wire vrms_power_pkg::phase_sample_t fund_v_sample, // first-harmonic voltage
  input  wire vrms_power_pkg::phase_sample_t fund_i_sample, // first-harmonic current
  input  wire vrms_power_pkg::reg_addr_t     reg_addr,      // register address
  input  wire logic                          reg_wr,        // write strobe
  input  wire logic                          reg_rd,        // read strobe
  input  wire vrms_power_pkg::reg_word_t     reg_wdata,     // write word
  output logic [`REG_W-1:0]                  reg_rdata,     // read word
  output logic                               reg_rvalid,    // read word valid pulse
  output logic                               rms_update     // rms set refreshed pulse
);
  import vrms_power_pkg::*;

  localparam int unsigned NPH = `NUM_PHASES;
  localparam int unsigned MIN_CYCLES = NPH * (`SQRT_STEPS + 2) + 2;

  if (RMS_SHIFT < 1 || RMS_SHIFT > `MAX_SHIFT) begin : g_chk_rms
    $error("vrms_offset_and_active_power: RMS_SHIFT out of range");
  end
  if (LPF_SHIFT < 1 || LPF_SHIFT > `MAX_SHIFT) begin : g_chk_lpf
    $error("vrms_offset_and_active_power: LPF_SHIFT out of range");
  end
  if (UPDATE_CYCLES < MIN_CYCLES || UPDATE_CYCLES > (1 << `TICK_CNT_W)) begin : g_chk_tick
    $error("vrms_offset_and_active_power: UPDATE_CYCLES out of range");
  end
  if (NPH > (1 << `PHASE_IDX_W) - 1) begin : g_chk_ph
    $error("vrms_offset_and_active_power: phase field too narrow");
  end

  // ****************************************************************
  // register storage
  // ****************************************************************
  sample_t    ofs_r   [NPH];
  sample_t    vrms_r  [NPH];
  sample_t    watt_r  [NPH];
  sample_t    fwatt_r [NPH];
  reg_word_t  rdata_r;
  logic       rvalid_r;
  logic       upd_r;

  // ****************************************************************
  // register decode
  // ****************************************************************
  // phase three and unknown groups read zero; their writes drop
  wire logic [`REG_ADDR_W-`PHASE_IDX_W-1:0] grp   = reg_addr[`REG_ADDR_W-1:`PHASE_IDX_W];
  wire phase_idx_t                          ph    = reg_addr[`PHASE_IDX_W-1:0];
  wire logic                                ph_ok = (ph < phase_idx_t'(NPH));
  wire logic sel_ofs   = ph_ok && (grp == `GRP_VRMS_OFS);
  wire logic sel_vrms  = ph_ok && (grp == `GRP_VRMS);
  wire logic sel_watt  = ph_ok && (grp == `GRP_WATT);
  wire logic sel_fwatt = ph_ok && (grp == `GRP_FWATT) && HAS_FUNDAMENTAL;
  wire logic ofs_wr    = reg_wr && sel_ofs;

  wire sample_t ofs_sel   = ofs_r[ph];
  wire sample_t vrms_sel  = vrms_r[ph];
  wire sample_t watt_sel  = watt_r[ph];
  wire sample_t fwatt_sel = fwatt_r[ph];

  // offset word: four zero msbs, then four sign bits and the 24-bit offset
  wire reg_word_t ofs_word = {`OFS_PAD_MSB, {`OFS_EXT_W{ofs_sel[`SAMPLE_W-1]}}, ofs_sel};
  wire reg_word_t vrms_word  = {`RESULT_PAD, vrms_sel};
  wire reg_word_t watt_word  = {`RESULT_PAD, watt_sel};
  wire reg_word_t fwatt_word = {`RESULT_PAD, fwatt_sel};
  wire reg_word_t rd_mux = sel_ofs   ? ofs_word   :
                           sel_vrms  ? vrms_word  :
                           sel_watt  ? watt_word  :
                           sel_fwatt ? fwatt_word : '0;

  // read word latched on each strobe, held until the next
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r  <= '0;
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= reg_rd;
      if (reg_rd) begin
        rdata_r <= rd_mux;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NPH; k++) begin
        ofs_r[k] <= `VRMS_OFS_RESET;
      end
    end else if (ofs_wr) begin
      // low word bits only; the top byte is padding
      ofs_r[ph] <= reg_wdata[`SAMPLE_W-1:0];
    end
  end

  // ****************************************************************
  // mean square of each voltage
  // ****************************************************************
  // running mean of v squared, one step per strobe
  sq_t                   ms_r    [NPH];
  sq_t                   ms_nxt  [NPH];
  logic signed [`SQ_W-1:0] v_ext [NPH];
  sq_t                   v_sq    [NPH];
  logic signed [`SQ_W:0] ms_diff [NPH];
  logic signed [`SQ_W:0] ms_sum  [NPH];

  for (genvar g = 0; g < NPH; g++) begin : g_ms
    assign v_ext[g]   = {{(`SQ_W-`SAMPLE_W){v_sample[g][`SAMPLE_W-1]}}, v_sample[g]};
    assign v_sq[g]    = sq_t'(v_ext[g] * v_ext[g]);
    assign ms_diff[g] = $signed({1'b0, v_sq[g]}) - $signed({1'b0, ms_r[g]});
    assign ms_sum[g]  = $signed({1'b0, ms_r[g]}) + (ms_diff[g] >>> RMS_SHIFT);
    assign ms_nxt[g]  = ms_sum[g][`SQ_W-1:0];
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NPH; k++) begin
        ms_r[k] <= '0;
      end
    end else if (sample_valid) begin
      for (int k = 0; k < NPH; k++) begin
        ms_r[k] <= ms_nxt[k];
      end
    end
  end

  // ****************************************************************
  // update tick
  // ****************************************************************
  // ticks during a pass are ignored; period floor keeps passes apart
  logic [`TICK_CNT_W-1:0] tick_cnt_r;
  wire logic tick = (tick_cnt_r == `TICK_CNT_W'(UPDATE_CYCLES - 1));

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick ? '0 : tick_cnt_r + 1'b1;
    end
  end

  // ****************************************************************
  // offset correction and shared square root
  // ****************************************************************
  rms_state_t             st_r;
  rms_state_t             st_nxt;
  phase_idx_t             idx_r;
  logic [`SQRT_CNT_W-1:0] sq_cnt_r;
  sq_t                    sq_op_r;
  sq_t                    sq_res_r;
  sq_t                    sq_one_r;

  // idx_r idles at three for a cycle; those lookups go unused
  // offset times 128 as a sign-kept shift by seven
  wire sample_t ofs_cur = ofs_r[idx_r];
  wire logic signed [`SQ_W:0] ofs_term =
    {{(`SQ_W+1-`SAMPLE_W-`VRMS_OFS_SHIFT){ofs_cur[`SAMPLE_W-1]}}, ofs_cur,
     {`VRMS_OFS_SHIFT{1'b0}}};
  wire logic signed [`SQ_W:0] corr_sum = $signed({1'b0, ms_r[idx_r]}) + ofs_term;
  wire sq_t radicand = corr_sum[`SQ_W] ? '0 : corr_sum[`SQ_W-1:0];

  // restoring root: two radicand bits retired per step
  wire sq_t  sq_try   = sq_res_r + sq_one_r;
  wire logic sq_ge    = (sq_op_r >= sq_try);
  wire sq_t  sq_op_n  = sq_ge ? (sq_op_r - sq_try) : sq_op_r;
  wire sq_t  sq_res_n = sq_ge ? ((sq_res_r >> 1) + sq_one_r) : (sq_res_r >> 1);
  wire logic sq_last  = (sq_cnt_r == `SQRT_CNT_W'(`SQRT_STEPS - 1));
  wire logic idx_last = (idx_r == phase_idx_t'(NPH - 1));
  wire sample_t root_sat = sq_res_r[`SAMPLE_W-1] ? `RMS_SAT_MAX : sq_res_r[`SAMPLE_W-1:0];

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      RMS_IDLE:  st_nxt = tick ? RMS_LOAD : RMS_IDLE;
      RMS_LOAD:  st_nxt = RMS_ITER;
      RMS_ITER:  st_nxt = sq_last ? RMS_STORE : RMS_ITER;
      RMS_STORE: st_nxt = idx_last ? RMS_IDLE : RMS_LOAD;
      default:   st_nxt = RMS_IDLE;
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      st_r  <= RMS_IDLE;
      idx_r <= '0;
      upd_r <= 1'b0;
    end else begin
      st_r  <= st_nxt;
      upd_r <= (st_r == RMS_STORE) && idx_last;
      if (st_r == RMS_IDLE) begin
        idx_r <= '0;
      end else if (st_r == RMS_STORE) begin
        idx_r <= idx_r + 1'b1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      sq_cnt_r <= '0;
      sq_op_r  <= '0;
      sq_res_r <= '0;
      sq_one_r <= '0;
    end else if (st_r == RMS_LOAD) begin
      sq_cnt_r <= '0;
      sq_op_r  <= radicand;
      sq_res_r <= '0;
      sq_one_r <= `SQRT_ONE_INIT;
    end else if (st_r == RMS_ITER) begin
      sq_cnt_r <= sq_cnt_r + 1'b1;
      sq_op_r  <= sq_op_n;
      sq_res_r <= sq_res_n;
      sq_one_r <= sq_one_r >> 2;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      for (int k = 0; k < NPH; k++) begin
        vrms_r[k] <= '0;
      end
    end else if (st_r == RMS_STORE) begin
      // root saturated to the signed result range
      vrms_r[idx_r] <= root_sat;
    end
  end

  // ****************************************************************
  // active power filters
  // ****************************************************************
  // total and fundamental paths share one filter design
  for (genvar g = 0; g < NPH; g++) begin : g_pwr
    power_path_if tot_if ();
    assign tot_if.sample_valid = sample_valid;
    assign tot_if.v_sample     = v_sample[g];
    assign tot_if.i_sample     = i_sample[g];

    power_lowpass_filter #(
      .LPF_SHIFT (LPF_SHIFT)
    ) u_tot (
      .core_clk (core_clk),
      .nrst     (nrst),
      .pp       (tot_if.filt)
    );

    always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
        watt_r[g] <= '0;
      end else if (tot_if.power_valid) begin
        watt_r[g] <= tot_if.power_out;
      end
    end

    if (HAS_FUNDAMENTAL) begin : g_fund
      power_path_if fund_if ();
      assign fund_if.sample_valid = sample_valid;
      assign fund_if.v_sample     = fund_v_sample[g];
      assign fund_if.i_sample     = fund_i_sample[g];

      power_lowpass_filter #(
        .LPF_SHIFT (LPF_SHIFT)
      ) u_fund (
        .core_clk (core_clk),
        .nrst     (nrst),
        .pp       (fund_if.filt)
      );

      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          fwatt_r[g] <= '0;
        end else if (fund_if.power_valid) begin
          fwatt_r[g] <= fund_if.power_out;
        end
      end
    end else begin : g_nofund
      always_ff @(posedge core_clk or negedge nrst) begin
        if (!nrst) begin
          fwatt_r[g] <= '0;
        end else begin
          fwatt_r[g] <= '0;
        end
      end
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  // outputs straight from registers
  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;
  assign rms_update = upd_r;
endmodule

// [dv/vrms_power_chk.sv]
// port checker for the rms offset and active power datapath
`timescale 1ns/1ps
`include "vrms_power_defines.svh"
module vrms_power_chk #(
  parameter int unsigned UPDATE_CYCLES = 3125
) (
  input wire logic                      core_clk,   // device clock
  input wire logic                      nrst,       // async reset, active low
  input wire vrms_power_pkg::reg_addr_t reg_addr,   // register address
  input wire logic                      reg_wr,     // write strobe
  input wire logic                      reg_rd,     // read strobe
  input wire vrms_power_pkg::reg_word_t reg_wdata,  // write word
  input wire logic [`REG_W-1:0]         reg_rdata,  // read word
  input wire logic                      reg_rvalid, // read word valid
  input wire logic                      rms_update  // rms refresh pulse
);
  import vrms_power_pkg::*;
  logic [15:0] gap_r;
  logic        seen_r;
  wire         ph_ok   = reg_addr[1:0] != 2'h3;
  wire         grp_ofs = ph_ok && reg_addr[7:2] == 6'h00;
  wire         grp_res = ph_ok && reg_addr[7:2] != 6'h00 && reg_addr[7:2] <= 6'h03;
  wire         unmap   = !ph_ok || reg_addr[7:2] > 6'h03;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!nrst);
  // ****************************************************************
  // refresh spacing counter
  // ****************************************************************
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b0;
    end else if (rms_update) begin
      gap_r  <= 16'h0000;
      seen_r <= 1'b1;
    end else begin
      gap_r  <= gap_r + 16'h0001;
    end
  end
  // ****************************************************************
  // properties
  // ****************************************************************
  rd_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read strobe not answered");
  rvalid_cause_a: assert property (reg_rvalid |-> $past(reg_rd))
    else $error("read valid without a read");
  rdata_hold_a: assert property (!reg_rvalid |-> $stable(reg_rdata))
    else $error("read word moved without a read");
  ofs_format_a: assert property (reg_rd && grp_ofs |=>
    reg_rdata[31:28] == 4'h0 && reg_rdata[27:24] == {4{reg_rdata[23]}})
    else $error("offset word badly padded");
  result_pad_a: assert property (reg_rd && grp_res |=> reg_rdata[31:24] == 8'h00)
    else $error("result word top byte not zero");
  rms_sign_a: assert property (reg_rd && reg_addr == {6'h01, reg_addr[1:0]} && ph_ok
    |=> !reg_rdata[23])
    else $error("rms result negative");
  unmapped_zero_a: assert property (reg_rd && unmap |=> reg_rdata == 32'h00000000)
    else $error("unmapped read not zero");
  ofs_store_a: assert property ((reg_wr && grp_ofs) ##1 (!reg_wr && !reg_rd)
    ##1 (reg_rd && !reg_wr && reg_addr == $past(reg_addr, 2))
    |=> reg_rdata[23:0] == $past(reg_wdata[23:0], 3))
    else $error("offset not stored");
  update_pulse_a: assert property (rms_update |=> !rms_update)
    else $error("refresh pulse too long");
  update_period_a: assert property (rms_update && seen_r |-> gap_r == UPDATE_CYCLES - 1)
    else $error("refresh period wrong");
endmodule
bind vrms_offset_and_active_power vrms_power_chk #(.UPDATE_CYCLES(UPDATE_CYCLES))
  i_vrms_power_chk (.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .reg_rvalid(reg_rvalid), .rms_update(rms_update));

// [dv/host_port_model.sv]
// host side model of the register word port
`timescale 1ns/1ps
`include "vrms_power_defines.svh"
module host_port_model (
  input  wire logic                 core_clk,   // device clock
  input  wire logic [`REG_W-1:0]    reg_rdata,  // read word
  input  wire logic                 reg_rvalid, // read word valid
  output vrms_power_pkg::reg_addr_t reg_addr,   // register address
  output logic                      reg_wr,     // write strobe
  output logic                      reg_rd,     // read strobe
  output vrms_power_pkg::reg_word_t reg_wdata   // write word
);
  import vrms_power_pkg::*;
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_wdata = 32'h00000000;
  end
  // released address and data show the inverse of the last value
  task automatic write_word(input reg_addr_t a, input logic [23:0] v);
    @(posedge core_clk);
    reg_addr  <= a;
    reg_wdata <= {4'h0, {4{v[23]}}, v};
    reg_wr    <= 1'b1;
    @(posedge core_clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~{4'h0, {4{v[23]}}, v};
  endtask
  task automatic read_word(input reg_addr_t a, output reg_word_t d, output bit ok);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge core_clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    ok = reg_rvalid === 1'b1;
    d  = reg_rdata;
  endtask
endmodule

// [dv/vrms_offset_and_active_power_tb.sv]
// self-checking bench for the rms offset and active power datapath
`timescale 1ns/1ps
`include "vrms_power_defines.svh"
module vrms_offset_and_active_power_tb;
  import vrms_power_pkg::*;
  localparam int unsigned UPD = 100;
  logic              core_clk, nrst, sample_valid, run, reg_wr, reg_rd, reg_rvalid, rms_update;
  phase_sample_t     v_sample, i_sample, fund_v_sample, fund_i_sample;
  reg_addr_t         reg_addr;
  reg_word_t         reg_wdata, rd_w;
  logic [`REG_W-1:0] reg_rdata;
  logic [31:0]       seed;
  int                miscompares, check_count, cyc;
  longint            vv[3], ii[3], fv[3], fi[3], oo[3];
  vrms_offset_and_active_power #(.RMS_SHIFT(2), .LPF_SHIFT(2), .UPDATE_CYCLES(UPD),
    .HAS_FUNDAMENTAL(1'b1)) i_vrms_offset_and_active_power (.core_clk(core_clk),
    .nrst(nrst), .sample_valid(sample_valid), .v_sample(v_sample), .i_sample(i_sample),
    .fund_v_sample(fund_v_sample), .fund_i_sample(fund_i_sample), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .rms_update(rms_update));
  host_port_model i_host_port_model (.core_clk(core_clk), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_wdata(reg_wdata));
  // ****************************************************************
  // expectation helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic longint rnd(input int sh);
    return longint'($signed(xs())) >>> sh;
  endfunction
  function automatic longint isq(input longint x);
    longint r;
    r = 0;
    for (int b = 23; b >= 0; b--) begin
      if ((r + (64'sh1 << b)) * (r + (64'sh1 << b)) <= x) begin
        r += 64'sh1 << b;
      end
    end
    return (r > 64'sh7fffff) ? 64'sh7fffff : r;
  endfunction
  function automatic longint pw(input longint p);
    longint q;
    q = p >>> 23;
    return (q > 64'sh7fffff) ? 64'sh7fffff : ((q < -64'sh800000) ? -64'sh800000 : q);
  endfunction
  // ****************************************************************
  // checks and closing
  // ****************************************************************
  task automatic fail(input string nm, input longint lo, input longint hi, input reg_word_t w);
    miscompares++;
    $display("CHECK FAILED %s expected %0d..%0d seen %h", nm, lo, hi, w);
  endtask
  task automatic rd(input reg_addr_t a);
    bit ok;
    i_host_port_model.read_word(a, rd_w, ok);
    check_count++;
    if (!ok) fail("rvalid", 1, 1, 32'h0);
  endtask
  task automatic chk_eq(input string nm, input reg_word_t e, input reg_word_t w);
    check_count++;
    if (w !== e) fail(nm, e, e, w);
  endtask
  task automatic chk_rng(input string nm, input longint lo, input longint hi, input reg_word_t w);
    check_count++;
    if ($isunknown(w) || w[31:24] !== 8'h00 || longint'($signed(w[23:0])) < lo
        || longint'($signed(w[23:0])) > hi) fail(nm, lo, hi, w);
  endtask
  task automatic wait_upd();
    int n;
    for (n = 0; n < 1000; n++) begin
      @(posedge core_clk);
      #1;
      if (rms_update === 1'b1) break;
    end
    check_count++;
    if (n == 1000) fail("rms_update", 1, 1, 32'h0);
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  // ****************************************************************
  // clock, samples, timeout
  // ****************************************************************
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    sample_valid <= run ? ~sample_valid : 1'b0;
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      summarize();
    end
  end
  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    logic [23:0] ov;
    longint      v2, lo;
    seed = 32'h4cab2c7c;
    nrst = 1'b0;
    run = 1'b0;
    sample_valid = 1'b0;
    {v_sample, i_sample, fund_v_sample, fund_i_sample} = '0;
    repeat (5) @(posedge core_clk);
    nrst <= 1'b1;
    for (int a = 0; a < 17; a++) begin
      rd((a == 16) ? 8'hff : a[7:0]);
      chk_eq("reset or unmapped", 32'h0, rd_w);
    end
    foreach (vv[p]) i_host_port_model.write_word((p == 2) ? 8'h03 : 8'h04 << p, 24'(xs()));
    for (int a = 0; a < 4; a++) begin
      rd(a[7:0]);
      chk_eq("offset after stray write", 32'h0, rd_w);
    end
    for (int p = 0; p < 3; p++) begin
      ov = (p == 0) ? 24'h800000 : ((p == 1) ? 24'h7fffff : xs());
      i_host_port_model.write_word(p[7:0], ov);
      rd(p[7:0]);
      chk_eq("offset word", {4'h0, {4{ov[23]}}, ov}, rd_w);
    end
    for (int r = 0; r < 4; r++) begin
      foreach (vv[p]) begin
        vv[p] = rnd(9);
        ii[p] = rnd(9);
        fv[p] = rnd(9);
        fi[p] = rnd(9);
        oo[p] = rnd(22) | 64'sh1;
      end
      if (r == 0) begin
        vv = '{64'sd1000, 64'sd1000, 64'sd4191910};
        ii[1] = -64'sd4191910;
        ii[2] = 64'sd4191910;
        oo = '{64'sd100, -64'sh10000, 64'sh0};
      end
      foreach (vv[p]) begin
        i_host_port_model.write_word(p[7:0], oo[p][23:0]);
        v_sample[p] <= sample_t'(vv[p]);
        i_sample[p] <= sample_t'(ii[p]);
        fund_v_sample[p] <= sample_t'(fv[p]);
        fund_i_sample[p] <= sample_t'(fi[p]);
      end
      run <= 1'b1;
      repeat (600) @(posedge core_clk);
      wait_upd();
      wait_upd();
      for (int p = 0; p < 3; p++) begin
        v2 = vv[p] * vv[p];
        lo = (v2 > 3) ? v2 - 3 : 0;
        rd(8'h04 + p[7:0]);
        chk_rng("rms", isq(lo + 128 * oo[p]), isq(v2 + 128 * oo[p]), rd_w);
        rd(8'h08 + p[7:0]);
        chk_rng("power", pw(vv[p] * ii[p] - 3), pw(vv[p] * ii[p]), rd_w);
        if (r == 0 && p == 2) begin
          lo = `FULL_SCALE_POWER_CONSTANT / 16;
          chk_rng("full scale power", lo, lo, rd_w);
        end
        rd(8'h0c + p[7:0]);
        chk_rng("fund power", pw(fv[p] * fi[p] - 3), pw(fv[p] * fi[p]), rd_w);
      end
    end
    summarize();
  end
endmodule
